// >>> hw/sic_sub_idle_ctrl.v
/*
 sub-idle wake controller: apb slave, sub-idle state, wake decision,
 peripheral clock gates. assumes a cpu and interrupt controller on pclk
 that present request lines and priority compare results.
*/
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "sic_defines.vh"
module sic_sub_idle_ctrl #(
    parameter NUM_MASKABLE = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire subclock_mode,
    input wire main_clock_running,
    input wire pin_nmi_req,
    input wire wdt_nmi_req,
    input wire [NUM_MASKABLE-1:0] maskable_req,
    input wire [NUM_MASKABLE-1:0] maskable_unmasked,
    input wire [NUM_MASKABLE-1:0] maskable_higher_prio,
    input wire global_irq_enabled,
    output wire cpu_halted,
    output reg nmi_ack,
    output reg maskable_ack,
    output reg resume_next,
    output wire return_to_subclock,
    output wire en_cpu,
    output wire en_rom_patch,
    output wire en_irq_ctrl,
    output wire en_general_timer16,
    output wire en_timer16_a,
    output wire en_timer16_b,
    output wire en_timer8_a,
    output wire en_timer8_b,
    output wire en_hires_timer_a,
    output wire en_hires_timer_b,
    output wire en_watch_counter,
    output wire en_wdt1,
    output wire en_wdt2,
    output wire en_sub_osc,
    output wire en_ring_osc,
    output wire en_sync_serial_a,
    output wire en_sync_serial_b
);
    // =====================================
    // registers
    reg [7:0] power_save_control_reg;
    reg [7:0] power_mode_select_reg;
    reg [8:0] clk_src_sel;
    reg in_sub_idle;
    reg [3:0] wake_status;
    // external request pins pass two flip-flops
    reg [1:0] nmi_meta;
    reg [1:0] nmi_sync;

    wire wr_en = psel & penable & pwrite;
    wire rd_ok;
    wire standby_kind_select = power_mode_select_reg[`SIC_PM_KIND];
    wire pin_nmi_wake_mask = power_save_control_reg[`SIC_PS_PIN_NMI_MASK];
    wire wdt_nmi_wake_mask = power_save_control_reg[`SIC_PS_WDT_NMI_MASK];
    wire maskable_wake_mask = power_save_control_reg[`SIC_PS_MASKABLE_MASK];

    // =====================================
    // apb: zero wait, error on unmapped address
    assign pready = 1'b1;
    assign rd_ok = (paddr == `SIC_OFF_PSAVE) || (paddr == `SIC_OFF_PMODE) ||
                   (paddr == `SIC_OFF_CLKSEL) || (paddr == `SIC_OFF_STATUS);
    assign pslverr = psel & penable & ~rd_ok;

    // read mux
    always @* begin
        case (paddr)
            `SIC_OFF_PSAVE: prdata = {24'h000000, power_save_control_reg};
            `SIC_OFF_PMODE: prdata = {24'h000000, power_mode_select_reg};
            `SIC_OFF_CLKSEL: prdata = {23'h000000, clk_src_sel};
            `SIC_OFF_STATUS: prdata = {28'h0000000, wake_status};
            default: prdata = 32'h00000000;
        endcase
    end

    // =====================================
    // synchronise the pin request lines
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_meta <= 2'b00;
            nmi_sync <= 2'b00;
        end else begin
            nmi_meta <= {wdt_nmi_req, pin_nmi_req};
            nmi_sync <= nmi_meta;
        end
    end

    // =====================================
    // wake decision
    wire nmi_wake = (nmi_sync[0] & ~pin_nmi_wake_mask) |
                    (nmi_sync[1] & ~wdt_nmi_wake_mask);
    wire [NUM_MASKABLE-1:0] mask_live = maskable_req & maskable_unmasked;
    wire mask_wake = (|mask_live) & ~maskable_wake_mask;
    wire mask_high = |(mask_live & maskable_higher_prio);
    wire any_wake = nmi_wake | mask_wake;
    wire enter_req = wr_en && (paddr == `SIC_OFF_PSAVE) &&
                     pwdata[`SIC_PS_STANDBY] && subclock_mode &&
                     !standby_kind_select;

    // sub-idle state, wake outcome, status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // reset in sub-idle is the ordinary reset
            in_sub_idle <= 1'b0;
            nmi_ack <= 1'b0;
            maskable_ack <= 1'b0;
            resume_next <= 1'b0;
            wake_status <= 4'h8; // reset wake restores normal mode
        end else begin
            nmi_ack <= 1'b0;
            maskable_ack <= 1'b0;
            resume_next <= 1'b0;
            if (in_sub_idle && any_wake) begin
                in_sub_idle <= 1'b0;
                wake_status <= {1'b0, mask_wake & ~nmi_wake, nmi_wake, 1'b0};
                if (nmi_wake) begin
                    nmi_ack <= 1'b1;
                end else if (global_irq_enabled && mask_high) begin
                    maskable_ack <= 1'b1;
                end else begin
                    resume_next <= 1'b1;
                end
            end else if (enter_req) begin
                in_sub_idle <= 1'b1;
                wake_status <= 4'h1;
            end
        end
    end

    // power save, mode select and clock source registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_save_control_reg <= `SIC_PS_RESET;
            power_mode_select_reg <= `SIC_PM_RESET;
            clk_src_sel <= `SIC_CS_RESET;
        end else begin
            if (in_sub_idle && any_wake) begin
                power_save_control_reg[`SIC_PS_STANDBY] <= 1'b0; // wake wins
            end else if (wr_en && paddr == `SIC_OFF_PSAVE) begin
                power_save_control_reg <= pwdata[7:0];
            end
            if (wr_en && paddr == `SIC_OFF_PMODE) begin
                power_mode_select_reg <= pwdata[7:0];
            end
            if (wr_en && paddr == `SIC_OFF_CLKSEL) begin
                clk_src_sel <= pwdata[8:0];
            end
        end
    end

    assign cpu_halted = in_sub_idle;
    assign return_to_subclock = wake_status[`SIC_ST_WAKE_NMI] |
                                wake_status[`SIC_ST_WAKE_MASK];

    // =====================================
    // clock gates while in sub-idle
    wire run = ~in_sub_idle;
    wire watch_on = main_clock_running | clk_src_sel[`SIC_CS_WATCH_SUB];
    wire t16b_ok = clk_src_sel[`SIC_CS_T16B_WATCH] & watch_on;
    assign en_cpu = run;
    assign en_rom_patch = run;
    assign en_irq_ctrl = run;
    assign en_general_timer16 = run;
    assign en_hires_timer_a = run;
    assign en_wdt1 = run;
    assign en_wdt2 = 1'b1;
    assign en_sub_osc = 1'b1;
    assign en_ring_osc = 1'b1;
    assign en_timer16_a = run;
    assign en_timer16_b = run | t16b_ok;
    assign en_timer8_a = run | clk_src_sel[`SIC_CS_T8A_EXT] |
                         (clk_src_sel[`SIC_CS_T8A_MATCH] & t16b_ok);
    assign en_timer8_b = run | clk_src_sel[`SIC_CS_T8B_EXT] |
                         (clk_src_sel[`SIC_CS_T8B_MATCH] & t16b_ok);
    assign en_hires_timer_b = run | clk_src_sel[`SIC_CS_HRB_DIV];
    assign en_watch_counter = run | watch_on;
    assign en_sync_serial_a = run | clk_src_sel[`SIC_CS_SSA_EXT];
    assign en_sync_serial_b = run | clk_src_sel[`SIC_CS_SSB_EXT];
endmodule

// >>> shared/sic_defines.vh
/*
 sub-idle wake controller constants: register byte offsets, field
 positions, reset values. assumes inclusion by the design file and the bench.
*/
`ifndef SIC_DEFINES_VH
`define SIC_DEFINES_VH
// =====================================
// register byte offsets
`define SIC_OFF_PSAVE 12'h000
`define SIC_OFF_PMODE 12'h004
`define SIC_OFF_CLKSEL 12'h008
`define SIC_OFF_STATUS 12'h00c
// =====================================
// power save control fields
`define SIC_PS_STANDBY 1
`define SIC_PS_MASKABLE_MASK 4
`define SIC_PS_PIN_NMI_MASK 5
`define SIC_PS_WDT_NMI_MASK 6
`define SIC_PS_RESET 8'h00
// =====================================
// power mode select fields
`define SIC_PM_KIND 0
`define SIC_PM_RESET 8'h01
// =====================================
// clock source select fields
`define SIC_CS_T16B_WATCH 0
`define SIC_CS_WATCH_SUB 1
`define SIC_CS_T8A_EXT 2
`define SIC_CS_T8A_MATCH 3
`define SIC_CS_T8B_EXT 4
`define SIC_CS_T8B_MATCH 5
`define SIC_CS_HRB_DIV 6
`define SIC_CS_SSA_EXT 7
`define SIC_CS_SSB_EXT 8
`define SIC_CS_RESET 9'h000
// =====================================
// status fields
`define SIC_ST_IDLE 0
`define SIC_ST_WAKE_NMI 1
`define SIC_ST_WAKE_MASK 2
`define SIC_ST_WAKE_RESET 3
`endif

// >>> tb/sic_props.sv
/* checker: wake pulses, ack choice and clock gates of the sub-idle controller.
   assumes binding onto sic_sub_idle_ctrl on pclk. */
`timescale 1ns/100ps
module sic_props #(
    parameter NUM_MASKABLE = 8
) (
    input wire pclk, presetn, cpu_halted, nmi_ack, maskable_ack, resume_next,
    input wire global_irq_enabled, main_clock_running, en_cpu, en_wdt1, en_hires_timer_a,
    input wire en_wdt2, en_sub_osc, en_ring_osc, en_timer16_a, en_watch_counter,
    input wire [NUM_MASKABLE-1:0] maskable_req, maskable_higher_prio
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // wake and gating
    a_wake_pulse: assert property ($fell(cpu_halted) == (nmi_ack | maskable_ack | resume_next))
        else $error("wake without pulse");
    a_one_pulse: assert property ($onehot0({nmi_ack, maskable_ack, resume_next}))
        else $error("two wake pulses");
    a_ack_prio: assert property (maskable_ack |-> $past(|(maskable_req & maskable_higher_prio)))
        else $error("lower priority acked");
    a_di_no_ack: assert property (maskable_ack |-> $past(global_irq_enabled))
        else $error("ack while disabled");
    a_nmi_halted: assert property (nmi_ack |-> $past(cpu_halted) && !cpu_halted)
        else $error("nmi ack outside wake");
    a_cpu_gated: assert property (cpu_halted |-> !(en_cpu | en_wdt1 | en_hires_timer_a))
        else $error("core clock not gated");
    a_osc_run: assert property (en_wdt2 && en_sub_osc && en_ring_osc)
        else $error("oscillator gated");
    a_t16a_halt: assert property (cpu_halted |-> ##0 !en_timer16_a)
        else $error("timer16_a runs");
    a_watch_main: assert property (cpu_halted && main_clock_running |-> en_watch_counter)
        else $error("watch stopped");
    c_nmi: cover property (nmi_ack);
    c_ack: cover property (maskable_ack);
    c_next: cover property (resume_next);
endmodule
bind sic_sub_idle_ctrl sic_props #(.NUM_MASKABLE(NUM_MASKABLE)) sic_props_inst (
    .pclk(pclk), .presetn(presetn), .cpu_halted(cpu_halted), .nmi_ack(nmi_ack),
    .maskable_ack(maskable_ack), .resume_next(resume_next), .en_cpu(en_cpu),
    .global_irq_enabled(global_irq_enabled), .main_clock_running(main_clock_running),
    .en_wdt1(en_wdt1), .en_hires_timer_a(en_hires_timer_a), .en_wdt2(en_wdt2),
    .en_sub_osc(en_sub_osc), .en_ring_osc(en_ring_osc), .en_timer16_a(en_timer16_a),
    .en_watch_counter(en_watch_counter), .maskable_req(maskable_req),
    .maskable_higher_prio(maskable_higher_prio));

// >>> tb/sic_irq_src.sv
/* interrupt source model: request lines, masks, priority compare.
   assumes drive() is called just after a pclk edge. */
`timescale 1ns/100ps
module sic_irq_src (
    input wire pclk,
    input wire maskable_ack,
    output logic pin_nmi_req, wdt_nmi_req, global_irq_enabled,
    output logic [7:0] maskable_req, maskable_unmasked, maskable_higher_prio
);
    initial {pin_nmi_req, wdt_nmi_req, global_irq_enabled, maskable_req} = 11'h000;
    initial {maskable_unmasked, maskable_higher_prio} = 16'hffff;
    // an acked request is consumed, an unacked one stays pending
    always @(posedge pclk) if (maskable_ack) maskable_req <= 8'h00;
    task drive(input logic [1:0] n, input logic [7:0] m, hp, input logic ie);
        {pin_nmi_req, wdt_nmi_req, maskable_req} <= {n, m};
        {maskable_higher_prio, global_irq_enabled} <= {hp, ie};
    endtask
endmodule

// >>> tb/tb_sub_idle_wake_control.sv
/* bench for the sub-idle wake controller.
   assumes design, irq source model and checker compiled first. */
`timescale 1ns/100ps
`include "sic_defines.vh"
module tb_sub_idle_wake_control;
    logic pclk, presetn, psel, penable, pwrite, sub, main_on, pready, pslverr, err;
    logic cpu_halted, nmi_ack, maskable_ack, resume_next, rts, pn, wn, ie;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] mr, mu, mh;
    logic [16:0] en;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    sic_irq_src sic_irq_src_inst (.pclk(pclk), .maskable_ack(maskable_ack), .pin_nmi_req(pn),
        .wdt_nmi_req(wn), .global_irq_enabled(ie), .maskable_req(mr),
        .maskable_unmasked(mu), .maskable_higher_prio(mh));
    sic_sub_idle_ctrl sic_sub_idle_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .subclock_mode(sub), .main_clock_running(main_on),
        .pin_nmi_req(pn), .wdt_nmi_req(wn), .maskable_req(mr), .maskable_unmasked(mu),
        .maskable_higher_prio(mh), .global_irq_enabled(ie), .cpu_halted(cpu_halted),
        .nmi_ack(nmi_ack), .maskable_ack(maskable_ack), .resume_next(resume_next),
        .return_to_subclock(rts), .en_cpu(en[0]), .en_rom_patch(en[1]), .en_irq_ctrl(en[2]),
        .en_general_timer16(en[3]), .en_timer16_a(en[4]), .en_timer16_b(en[5]),
        .en_timer8_a(en[6]), .en_timer8_b(en[7]), .en_hires_timer_a(en[8]),
        .en_hires_timer_b(en[9]), .en_watch_counter(en[10]), .en_wdt1(en[11]),
        .en_wdt2(en[12]), .en_sub_osc(en[13]), .en_ring_osc(en[14]),
        .en_sync_serial_a(en[15]), .en_sync_serial_b(en[16]));
    // ==========
    // clock and hang guard
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // apb transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task do_reset();
        presetn <= 0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
    endtask
    // ==========
    // scenarios
    task t_reset();
        apb(0, `SIC_OFF_STATUS, 0);
        chk(rd, 32'h8);
        apb(0, `SIC_OFF_PMODE, 0);
        chk(rd, 32'h1);
        apb(1, 12'h010, 32'h5);
        chk({pready, err, cpu_halted, rts, en}, {4'b1100, 17'h1ffff});
    endtask
    task enter(input logic [31:0] ps);
        apb(1, `SIC_OFF_PMODE, 0);
        apb(1, `SIC_OFF_PSAVE, ps);
        @(posedge pclk);
        chk(cpu_halted, 1);
    endtask
    task t_masked();
        enter(32'h72);
        sic_irq_src_inst.drive(2'b11, 8'h01, 8'hff, 1);
        repeat (10) @(posedge pclk);
        chk(cpu_halted, 1);
        sic_irq_src_inst.drive(0, 0, 8'hff, 0);
        do_reset();
        t_reset();
    endtask
    task t_wake_table();
        logic [7:0] wt[5] = '{8'h94, 8'h4c, 8'h3a, 8'h29, 8'h31};
        logic [16:0] eg[3] = '{17'h07000, 17'h07400, 17'h1f6e0};
        logic [2:0] got;
        int i, k;
        for (i = 0; i < 5; i++) begin
            main_on <= (i == 1);
            apb(1, `SIC_OFF_CLKSEL, (i == 2) ? 32'h1ff : 32'h0);
            enter(32'h2);
            if (i < 3) chk(en, eg[i]);
            got = 0;
            sic_irq_src_inst.drive(wt[i][7:6], {7'h0, wt[i][5]}, {8{wt[i][4]}}, wt[i][3]);
            for (k = 0; k < 8; k++) begin
                @(posedge pclk);
                got |= {nmi_ack, maskable_ack, resume_next};
            end
            chk({got, cpu_halted, rts}, {wt[i][2:0], 2'b01});
            chk(mr[0], wt[i][5] & !wt[i][1]);
            sic_irq_src_inst.drive(0, 0, 8'hff, 0);
        end
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, sub, main_on} = 0;
        sub = 1;
        presetn = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_wake_table();
        t_masked();
        report_and_stop();
    end
endmodule
